// file: include/pbc_cfg.svh
// Register offsets, write masks, field positions and reset values of the blanking and chop block.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH
`define PBC_ADDR_BLANK_CTRL 5'h00
`define PBC_ADDR_BLANK_DLY  5'h04
`define PBC_ADDR_AUX_CTRL   5'h08
`define PBC_ADDR_OUT_LEVELS 5'h0c
`define PBC_ADDR_STATUS     5'h10
`define PBC_CTRL_WMASK      16'hfc3f
`define PBC_DLY_WMASK       16'h0fff
`define PBC_AUX_WMASK       16'h0f3f
`define PBC_LVL_WMASK       16'h000f
`define PBC_RST_CTRL        16'h0000
`define PBC_RST_DLY         16'h0000
`define PBC_RST_AUX         16'h0000
`define PBC_RST_LVL         16'h0000
`define PBC_B_HI_RISE  15
`define PBC_B_HI_FALL  14
`define PBC_B_LO_RISE  13
`define PBC_B_LO_FALL  12
`define PBC_B_FLT_LEB  11
`define PBC_B_LIM_LEB  10
`define PBC_B_SRC_HI   5
`define PBC_B_SRC_LO   4
`define PBC_B_HO_HI    3
`define PBC_B_HO_LO    2
`define PBC_B_LO_HI    1
`define PBC_B_LO_LO    0
`define PBC_F_BSEL_HI  11
`define PBC_F_BSEL_LO  8
`define PBC_F_CSEL_HI  5
`define PBC_F_CSEL_LO  2
`define PBC_B_HI_CHOP  1
`define PBC_B_LO_CHOP  0
`define PBC_F_DLY_HI   11
`define PBC_B_FLT_LVH  3
`define PBC_B_FLT_LVL  2
`define PBC_B_LIM_LVH  1
`define PBC_B_LIM_LVL  0
`endif

// file: include/pbc_pkg.sv
// Types shared by the blanking and chop block.
// Assumes pbc_cfg.svh holds the register numbers; the source select codes are defined here.
package pbc_pkg;
   typedef enum logic [3:0] {
      PBC_SRC_NONE = 4'h0,
      PBC_SRC_GEN1 = 4'h1,
      PBC_SRC_GEN2 = 4'h2,
      PBC_SRC_GEN3 = 4'h3
   } pbc_src_e;
   typedef logic [15:0] pbc_reg_t;
endpackage

// file: logic/pbc_blank_timer.sv
// Leading-edge blanking down-counter.
// Assumes a restart pulse synchronous to clk_i.
`timescale 1ns/1ps
module pbc_blank_timer #(
   parameter int DLY_W = 12
) (
   // Clock, reset and enable.
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             ce_i,
   // Control.
   input  wire logic             restart_i,
   input  wire logic [DLY_W-1:0] delay_i,
   // Status.
   output logic                  active_o,
   output logic [DLY_W-1:0]      count_o
);
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         count_o <= '0;
      end else if (ce_i) begin
         if (restart_i) begin
            count_o <= delay_i;
         end else if (count_o != '0) begin
            count_o <= count_o - 1'b1;
         end
      end
   end

   assign active_o = (count_o != '0);

   property p_timer_reload;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && restart_i) |=> (count_o == $past(delay_i));
   endproperty
   a_timer_reload: assert property (p_timer_reload) else $error("timer reload wrong");

   property p_timer_down;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && !restart_i && count_o != '0) |=> (count_o == $past(count_o) - 1'b1);
   endproperty
   a_timer_down: assert property (p_timer_down) else $error("timer did not count down");
endmodule

// file: logic/pbc_top.sv
// Blanking, fault forcing and chop logic of one PWM generator.
// Assumes PWM and fault inputs are synchronous to clk_i; Avalon-MM register port.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "pbc_cfg.svh"
module pbc_top #(
   parameter int DLY_W = 12
) (
   // Clock, reset and enable.
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   // Avalon-MM slave.
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Generator outputs and sources.
   input  wire logic        pwm_high_in_i,
   input  wire logic        pwm_low_in_i,
   input  wire logic [2:0]  gen_high_i,
   input  wire logic        chop_clk_i,
   // Protection inputs, active high after polarity selection.
   input  wire logic        fault_i,
   input  wire logic        limit_i,
   // Results.
   output logic             pwm_high_out_o,
   output logic             pwm_low_out_o,
   output logic             fault_eff_o,
   output logic             limit_eff_o
);
   ////////////////////////////////////////////////////////////////////////////////
   pbc_pkg::pbc_reg_t blank_control;
   pbc_pkg::pbc_reg_t blank_delay;
   pbc_pkg::pbc_reg_t aux_control;
   pbc_pkg::pbc_reg_t out_levels;
   logic              hi_q;
   logic              lo_q;
   logic              restart;
   logic              edge_active;
   logic [DLY_W-1:0]  count;
   logic              blank_src;
   logic              chop_src;
   logic              state_blank;
   logic              flt_mask;
   logic              lim_mask;
   logic              ack;
   logic [15:0]       next_rdata;

   function automatic logic pick_src(input logic [3:0] sel, input logic [2:0] gen,
                                     input logic none_val);
      unique case (sel)
         pbc_pkg::PBC_SRC_GEN1: pick_src = gen[0];
         pbc_pkg::PBC_SRC_GEN2: pick_src = gen[1];
         pbc_pkg::PBC_SRC_GEN3: pick_src = gen[2];
         default:               pick_src = none_val;
      endcase
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [15:0] m);
      logic [15:0] n;
      n = old;
      if (be[0]) begin
         n[7:0] = wd[7:0];
      end
      if (be[1]) begin
         n[15:8] = wd[15:8];
      end
      merge = n & m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Registers answer with one wait cycle, then acknowledge.
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read_i || avs_write_i) && !ack;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         blank_control <= `PBC_RST_CTRL;
         blank_delay   <= `PBC_RST_DLY;
         aux_control   <= `PBC_RST_AUX;
         out_levels    <= `PBC_RST_LVL;
      end else if (avs_write_i && ack) begin
         unique case ({avs_address_i[4:2], 2'b00})
            `PBC_ADDR_BLANK_CTRL: blank_control <= merge(blank_control, avs_writedata_i,
                                        avs_byteenable_i, `PBC_CTRL_WMASK);
            `PBC_ADDR_BLANK_DLY:  blank_delay <= merge(blank_delay, avs_writedata_i,
                                        avs_byteenable_i, `PBC_DLY_WMASK);
            `PBC_ADDR_AUX_CTRL:   aux_control <= merge(aux_control, avs_writedata_i,
                                        avs_byteenable_i, `PBC_AUX_WMASK);
            `PBC_ADDR_OUT_LEVELS: out_levels <= merge(out_levels, avs_writedata_i,
                                        avs_byteenable_i, `PBC_LVL_WMASK);
            default: ;
         endcase
      end
   end

   always_comb begin
      next_rdata = 16'h0000;
      unique case ({avs_address_i[4:2], 2'b00})
         `PBC_ADDR_BLANK_CTRL: next_rdata = blank_control;
         `PBC_ADDR_BLANK_DLY:  next_rdata = blank_delay;
         `PBC_ADDR_AUX_CTRL:   next_rdata = aux_control;
         `PBC_ADDR_OUT_LEVELS: next_rdata = out_levels;
         `PBC_ADDR_STATUS:     next_rdata = {edge_active, fault_eff_o, limit_eff_o,
                                             1'b0, count};
         default:              next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && !ack) begin
         avs_readdata_o <= {16'h0000, next_rdata};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection of the generator outputs.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hi_q <= 1'b0;
         lo_q <= 1'b0;
      end else if (ce_i) begin
         hi_q <= pwm_high_in_i;
         lo_q <= pwm_low_in_i;
      end
   end

   assign restart = (blank_control[`PBC_B_HI_RISE] && pwm_high_in_i && !hi_q)
                 || (blank_control[`PBC_B_HI_FALL] && !pwm_high_in_i && hi_q)
                 || (blank_control[`PBC_B_LO_RISE] && pwm_low_in_i && !lo_q)
                 || (blank_control[`PBC_B_LO_FALL] && !pwm_low_in_i && lo_q);

   pbc_blank_timer #(
      .DLY_W (DLY_W)
   ) u_timer (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .restart_i (restart),
      .delay_i   (blank_delay[DLY_W-1:0]),
      .active_o  (edge_active),
      .count_o   (count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State blanking and masking.
   assign blank_src = pick_src(aux_control[`PBC_F_BSEL_HI:`PBC_F_BSEL_LO],
                               gen_high_i, 1'b0);

   assign state_blank =
      (aux_control[`PBC_F_BSEL_HI:`PBC_F_BSEL_LO] inside {4'h1, 4'h2, 4'h3} &&
       ((blank_control[`PBC_B_SRC_HI] && blank_src)
        || (blank_control[`PBC_B_SRC_LO] && !blank_src)))
      || (blank_control[`PBC_B_HO_HI] && pwm_high_in_i)
      || (blank_control[`PBC_B_HO_LO] && !pwm_high_in_i)
      || (blank_control[`PBC_B_LO_HI] && pwm_low_in_i)
      || (blank_control[`PBC_B_LO_LO] && !pwm_low_in_i);

   assign flt_mask = (blank_control[`PBC_B_FLT_LEB] && edge_active) || state_blank;
   assign lim_mask = (blank_control[`PBC_B_LIM_LEB] && edge_active) || state_blank;

   ////////////////////////////////////////////////////////////////////////////////
   // Chop and forced output levels.
   assign chop_src = pick_src(aux_control[`PBC_F_CSEL_HI:`PBC_F_CSEL_LO],
                              gen_high_i, chop_clk_i);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fault_eff_o    <= 1'b0;
         limit_eff_o    <= 1'b0;
         pwm_high_out_o <= 1'b0;
         pwm_low_out_o  <= 1'b0;
      end else if (ce_i) begin
         fault_eff_o <= fault_i && !flt_mask;
         limit_eff_o <= limit_i && !lim_mask;
         if (fault_i && !flt_mask) begin
            pwm_high_out_o <= out_levels[`PBC_B_FLT_LVH];
            pwm_low_out_o  <= out_levels[`PBC_B_FLT_LVL];
         end else if (limit_i && !lim_mask) begin
            pwm_high_out_o <= out_levels[`PBC_B_LIM_LVH];
            pwm_low_out_o  <= out_levels[`PBC_B_LIM_LVL];
         end else begin
            pwm_high_out_o <= pwm_high_in_i &&
                              (!aux_control[`PBC_B_HI_CHOP] || chop_src);
            pwm_low_out_o  <= pwm_low_in_i &&
                              (!aux_control[`PBC_B_LO_CHOP] || chop_src);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_hi_rise;
      ce_i && blank_control[`PBC_B_HI_RISE] && pwm_high_in_i && !hi_q;
   endsequence

   sequence s_blank_on;
      edge_active;
   endsequence

   property p_hi_rise;
      @(posedge clk_i) disable iff (srst_i)
      (s_hi_rise and (blank_delay[DLY_W-1:0] != '0)) |=> s_blank_on;
   endproperty
   a_hi_rise: assert property (p_hi_rise) else $error("high rise did not blank");

   property p_lo_fall;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && blank_control[`PBC_B_LO_FALL] && !pwm_low_in_i && lo_q)
         |=> (count == $past(blank_delay[DLY_W-1:0]));
   endproperty
   a_lo_fall: assert property (p_lo_fall) else $error("low fall did not reload");

   property p_fault_force;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && fault_i && !flt_mask)
         |=> (fault_eff_o && pwm_high_out_o == $past(out_levels[`PBC_B_FLT_LVH])
              && pwm_low_out_o == $past(out_levels[`PBC_B_FLT_LVL]));
   endproperty
   a_fault_force: assert property (p_fault_force) else $error("fault level not forced");

   property p_limit_force;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && !fault_i && limit_i && !lim_mask)
         |=> (pwm_high_out_o == $past(out_levels[`PBC_B_LIM_LVH]));
   endproperty
   a_limit_force: assert property (p_limit_force) else $error("limit level not forced");

   property p_flt_leb;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && edge_active && blank_control[`PBC_B_FLT_LEB]) |=> !fault_eff_o;
   endproperty
   a_flt_leb: assert property (p_flt_leb) else $error("fault passed in blanking");

   property p_lim_leb;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && edge_active && blank_control[`PBC_B_LIM_LEB]) |=> !limit_eff_o;
   endproperty
   a_lim_leb: assert property (p_lim_leb) else $error("limit passed in blanking");

   property p_ho_state;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && blank_control[`PBC_B_HO_HI] && pwm_high_in_i) |=> !limit_eff_o && !fault_eff_o;
   endproperty
   a_ho_state: assert property (p_ho_state) else $error("state blank failed");

   property p_dly_top;
      @(posedge clk_i) disable iff (srst_i)
      blank_delay[15:12] == 4'h0 && aux_control[7:6] == 2'b00;
   endproperty
   a_dly_top: assert property (p_dly_top) else $error("unused bits set");

   property p_chop_off;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && !fault_i && !limit_i && !aux_control[`PBC_B_HI_CHOP])
         |=> (pwm_high_out_o == $past(pwm_high_in_i));
   endproperty
   a_chop_off: assert property (p_chop_off) else $error("unchopped output altered");
endmodule

// file: testbench/pbc_far_model.sv
// Model of the generator outputs, chop clock and protection comparators.
// Assumes the bench sets the commanded levels just after a rising clock edge.
`timescale 1ns/1ps
module pbc_far_model (
   // Clock.
   input  wire logic       clk_i,
   // Commanded levels {high, low, generators, chop, fault, limit}.
   input  wire logic [7:0] cmd_i,
   // Levels seen by the block.
   output logic            pwm_high_o,
   output logic            pwm_low_o,
   output logic [2:0]      gen_high_o,
   output logic            chop_clk_o,
   output logic            fault_o,
   output logic            limit_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Every source changes one clock after it is commanded, as a real generator does.
   always_ff @(posedge clk_i) begin
      {pwm_high_o, pwm_low_o, gen_high_o, chop_clk_o, fault_o, limit_o} <= cmd_i;
   end
endmodule

// file: testbench/testbench.sv
// Self-checking bench of the blanking and chop block.
// Assumes the far-side model in pbc_far_model.sv and the register map of pbc_cfg.svh.
`timescale 1ns/1ps
`include "pbc_cfg.svh"
module testbench;
   typedef struct packed {logic [4:0] a; logic [15:0] w; logic [15:0] r;} pbc_reg_row_s;
   typedef struct packed {
      logic [15:0] ctrl; logic [15:0] aux; logic [3:0] lvl;
      logic [1:0] pwm; logic [2:0] gen; logic chop; logic [1:0] flt; logic [3:0] e;
   } pbc_dp_row_s;
   typedef struct packed {
      logic [15:0] ctrl; logic [1:0] pre; logic [1:0] post; logic [1:0] e;
   } pbc_edge_row_s;
   logic        clk_i, srst_i;
   logic        ce;
   logic [3:0]  outs;
   logic [4:0]  avs_address_i;
   logic        avs_read_i, avs_write_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   logic        avs_waitrequest_o, pwm_high_out_o, pwm_low_out_o, fault_eff_o, limit_eff_o;
   logic        hi_w, lo_w, chop_w, flt_w, lim_w;
   logic [2:0]  gen_w;
   logic [7:0]  cmd;
   int          bad_count, total_checks;
   pbc_reg_row_s regs[5] = '{'{5'h00, 16'hffff, `PBC_CTRL_WMASK},
      '{5'h04, 16'hffff, `PBC_DLY_WMASK}, '{5'h08, 16'hffff, `PBC_AUX_WMASK},
      '{5'h0c, 16'hffff, `PBC_LVL_WMASK}, '{5'h14, 16'hffff, 16'h0}};
   pbc_dp_row_s dps[20] = '{
      '{16'h0000, 16'h0000, 4'h9, 2'b11, 3'h0, 1'b0, 2'b10, 4'ha},
      '{16'h0000, 16'h0000, 4'h9, 2'b11, 3'h0, 1'b0, 2'b01, 4'h5},
      '{16'h0000, 16'h0000, 4'h9, 2'b11, 3'h0, 1'b0, 2'b11, 4'hb},
      '{16'h0008, 16'h0000, 4'h8, 2'b10, 3'h0, 1'b0, 2'b11, 4'h8},
      '{16'h0008, 16'h0000, 4'h0, 2'b00, 3'h0, 1'b0, 2'b11, 4'h3},
      '{16'h0004, 16'h0000, 4'h0, 2'b00, 3'h0, 1'b0, 2'b11, 4'h0},
      '{16'h0002, 16'h0000, 4'h4, 2'b01, 3'h0, 1'b0, 2'b11, 4'h4},
      '{16'h0001, 16'h0000, 4'h4, 2'b01, 3'h0, 1'b0, 2'b11, 4'h7},
      '{16'h0020, 16'h0100, 4'h0, 2'b00, 3'h1, 1'b0, 2'b11, 4'h0},
      '{16'h0020, 16'h0300, 4'h0, 2'b00, 3'h3, 1'b0, 2'b11, 4'h3},
      '{16'h0010, 16'h0200, 4'h0, 2'b00, 3'h5, 1'b0, 2'b11, 4'h0},
      '{16'h0030, 16'h0500, 4'h0, 2'b00, 3'h0, 1'b0, 2'b11, 4'h3},
      '{16'h0000, 16'h0002, 4'h0, 2'b11, 3'h0, 1'b0, 2'b00, 4'h4},
      '{16'h0000, 16'h0002, 4'h0, 2'b11, 3'h0, 1'b1, 2'b00, 4'hc},
      '{16'h0000, 16'h0001, 4'h0, 2'b11, 3'h7, 1'b0, 2'b00, 4'h8},
      '{16'h0000, 16'h0006, 4'h0, 2'b11, 3'h6, 1'b1, 2'b00, 4'h4},
      '{16'h0000, 16'h000a, 4'h0, 2'b11, 3'h2, 1'b0, 2'b00, 4'hc},
      '{16'h0000, 16'h000f, 4'h0, 2'b11, 3'h3, 1'b1, 2'b00, 4'h0},
      '{16'h0000, 16'h000f, 4'h0, 2'b11, 3'h4, 1'b0, 2'b00, 4'hc},
      '{16'h0000, 16'h0016, 4'h0, 2'b11, 3'h7, 1'b0, 2'b00, 4'h4}};
   pbc_edge_row_s eds[6] = '{'{16'h8c00, 2'b00, 2'b10, 2'b00}, '{16'h8800, 2'b10, 2'b00, 2'b11},
      '{16'h4800, 2'b10, 2'b00, 2'b01}, '{16'h2400, 2'b00, 2'b01, 2'b10},
      '{16'h1c00, 2'b01, 2'b00, 2'b00}, '{16'h1c00, 2'b00, 2'b01, 2'b11}};

   pbc_far_model u_pbc_far_model (.clk_i(clk_i), .cmd_i(cmd), .pwm_high_o(hi_w), .pwm_low_o(lo_w),
      .gen_high_o(gen_w), .chop_clk_o(chop_w), .fault_o(flt_w), .limit_o(lim_w));
   pbc_top u_pbc_top (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'h3), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .pwm_high_in_i(hi_w), .pwm_low_in_i(lo_w),
      .gen_high_i(gen_w), .chop_clk_i(chop_w), .fault_i(flt_w), .limit_i(lim_w),
      .pwm_high_out_o(pwm_high_out_o), .pwm_low_out_o(pwm_low_out_o),
      .fault_eff_o(fault_eff_o), .limit_eff_o(limit_eff_o));

   assign outs = {pwm_high_out_o, pwm_low_out_o, fault_eff_o, limit_eff_o};

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= {16'h0000, d};
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do begin
         @(posedge clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      bad_count = 0;
      total_checks = 0;
      srst_i = 1'b1;
      ce = 1'b1;
      avs_address_i = 5'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      cmd = 8'h00;
      tick(5);
      srst_i <= 1'b0;
      foreach (regs[i]) begin
         bus(1'b1, regs[i].a, regs[i].w);
         bus(1'b0, regs[i].a, 16'h0000);
         chk(q, {16'h0000, regs[i].r});
      end
      $display("Register access test done");
      foreach (dps[i]) begin
         bus(1'b1, 5'h00, dps[i].ctrl);
         bus(1'b1, 5'h08, dps[i].aux);
         bus(1'b1, 5'h0c, {12'h000, dps[i].lvl});
         @(posedge clk_i);
         cmd <= {dps[i].pwm, dps[i].gen, dps[i].chop, dps[i].flt};
         tick(4);
         chk(outs[3:2], dps[i].e[3:2]);
         chk(outs[1:0], dps[i].e[1:0]);
      end
      $display("State blanking, forcing and chop test done");
      bus(1'b1, 5'h08, 16'h0000);
      bus(1'b1, 5'h0c, 16'h0000);
      bus(1'b1, 5'h04, 16'h0014);
      foreach (eds[i]) begin
         bus(1'b1, 5'h00, eds[i].ctrl);
         @(posedge clk_i);
         cmd <= {eds[i].pre, 6'h00};
         tick(30);
         cmd <= {eds[i].post, 6'h00};
         tick(3);
         cmd <= {eds[i].post, 6'h03};
         tick(4);
         chk(outs[1:0], eds[i].e);
         tick(30);
         chk(outs[1:0], 2'b11);
         cmd <= {eds[i].post, 6'h00};
      end
      $display("Edge blanking test done");
      tick(4);
      ce <= 1'b0;
      cmd <= 8'h42;
      tick(4);
      chk(outs[1:0], 2'b00);
      ce <= 1'b1;
      tick(2);
      chk(outs[1:0], 2'b10);
      $display("Clock enable test done");
      @(posedge clk_i);
      srst_i <= 1'b1;
      cmd <= 8'h00;
      tick(2);
      srst_i <= 1'b0;
      for (int a = 0; a < 20; a += 4) begin
         bus(1'b0, 5'(a), 16'h0000);
         chk(q, 32'h0);
      end
      $display("Second reset test done");
      print_verdict();
   end

   initial begin
      tick(20000);
      bad_count++;
      print_verdict();
   end
endmodule
